// ==== hw/dhp_pkg.sv ====
// Shared constants for the DMA pin polarity and interrupt cause block
package dhp_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CMD   = 8'h30;
	localparam logic [7:0] ADDR_CNT   = 8'h34;
	localparam logic [7:0] ADDR_CFG   = 8'h38;
	localparam logic [7:0] ADDR_HW    = 8'h3C;
	localparam logic [7:0] ADDR_CAUSE = 8'h50;

	// Pin polarity and byte order register fields
	localparam int         HW_ORD_LO  = 6;
	localparam int         HW_EOT     = 5;
	localparam int         HW_ACK     = 3;
	localparam int         HW_REQ     = 2;
	localparam int         HW_WR      = 1;
	localparam int         HW_RD      = 0;
	localparam logic [7:0] HW_RST     = 8'h04;
	localparam logic [7:0] HW_WR_MASK = 8'hEF;
	localparam logic [1:0] ORD_SWAP   = 2'h1;

	// Configuration register fields
	localparam int         CFG_WIDTH     = 0;
	localparam logic       CFG_WIDTH_RST = 1'h1;

	// Command codes
	localparam logic [7:0] CMD_STOP = 8'h13;

	// Interrupt cause register fields
	localparam int          CA_CUT   = 15;
	localparam int          CA_STOP  = 12;
	localparam int          CA_EXT   = 11;
	localparam int          CA_INT   = 10;
	localparam int          CA_CNT   = 8;
	localparam logic [15:0] CA_CLR_M = 16'h1D00;
	localparam logic [15:0] CA_RST   = 16'h0000;

	// Counter steps per strobe
	localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
	localparam logic [31:0] STEP_WORD = 32'h0000_0002;

	// Bus answers
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// Transfer states
	typedef enum logic [0:0] {
		ST_IDLE = 1'h0,
		ST_RUN  = 1'h1
	} dhp_state_e;

endpackage

// ==== hw/dhp_top.sv ====
// DMA handshake pin polarity, byte order and interrupt cause logic
`timescale 1ns/1ns

// How it works
// - Byte order 00 on a 16-bit bus keeps high byte on upper lines.
// - Byte order 01 swaps the bytes; codes 10 and 11 are reserved.
// - Bit 5 picks the end-of-transfer input level, 1 meaning active high.
// - Bit 3 picks the acknowledge input level, 1 meaning active high.
// - Bit 2 picks the request output level; resets to 1 on both resets.
// - Bit 1 picks the write strobe level, 1 meaning active high.
// - Bit 0 picks the read strobe level, 1 meaning active high.
// - All cause bits are refreshed whenever a command finishes.
// - Writing 1 clears a cause bit, writing 0 leaves it alone.
// - Bit 15 flags an OUT packet cut short; writes cannot change it.
// - Bit 12 flags a stop command that ended the transfer.
// - Bit 11 flags an asserted external end input, polarity applied.
// - Bit 10 flags an internal end of transfer.
// - Bit 8 flags completion by the byte counter reaching zero.
// - Short packet before zero count sets internal end only.
// - Short packet with zero count sets both internal end and count bits.
// - Zero count without short packet sets count bit only.
// - The byte counter holds bytes left and counts down as bytes move.
// - Stop halts, keeps OUT data, flushes the IN FIFO and flags done in the same cycle.
// - Request pin stays undriven until configuration is written once.
module dhp_top
	import dhp_pkg::*;
(
	// Clock and resets
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	input  wire logic        usb_bus_reset_i,
	// AXI4-Lite write channels
	input  wire logic        s_axi_awvalid_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	output logic             s_axi_awready_o,
	input  wire logic        s_axi_wvalid_i,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	output logic             s_axi_wready_o,
	output logic             s_axi_bvalid_o,
	output logic [1:0]       s_axi_bresp_o,
	input  wire logic        s_axi_bready_i,
	// AXI4-Lite read channels
	input  wire logic        s_axi_arvalid_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	output logic             s_axi_arready_o,
	output logic             s_axi_rvalid_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	input  wire logic        s_axi_rready_i,
	// DMA handshake pins
	input  wire logic        transfer_end_input_i,
	input  wire logic        dma_acknowledge_input_i,
	input  wire logic        dma_read_strobe_i,
	input  wire logic        dma_write_strobe_i,
	output logic             dma_request_output_o,
	output logic             dma_request_output_oe_o,
	// DMA data bus
	input  wire logic [15:0] dma_data_i,
	output logic [15:0]      dma_data_o,
	output logic             dma_data_oe_o,
	// Endpoint buffer side
	input  wire logic [15:0] ep_rd_word_i,
	output logic             ep_rd_take_o,
	output logic [15:0]      ep_wr_word_o,
	output logic             ep_wr_valid_o,
	output logic             in_flush_o,
	input  wire logic        short_packet_i,
	input  wire logic        out_cut_short_i
);

	logic        awready_ff;
	logic        arready_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic [7:0]  hw_ff;
	logic        cfg_width_ff;
	logic        cfg_written_ff;
	logic [31:0] cnt_ff;
	logic        start_ff;
	logic [15:0] cause_ff;
	logic        out_cut_ff;
	dhp_state_e  state_ff;
	logic [19:0] sync1_ff;
	logic [19:0] sync2_ff;
	logic [3:0]  act_prev_ff;
	logic        req_ff;
	logic        req_oe_ff;
	logic [15:0] data_o_ff;
	logic        data_oe_ff;
	logic        rd_take_ff;
	logic [15:0] ep_wr_word_ff;
	logic        ep_wr_valid_ff;
	logic        flush_ff;

	logic        wr_en;
	logic        wr_hit;
	logic        stop_req;
	logic        run;
	logic        swap;
	logic        rd_act;
	logic        wr_act;
	logic        ack_act;
	logic        eot_act;
	logic        rd_rise;
	logic        wr_rise;
	logic        ext_rise;
	logic        moves;
	logic [31:0] step;
	logic [31:0] nxt_cnt;
	logic        cnt_hit;
	logic        finish;
	logic        req_on;
	logic [15:0] nxt_cause;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic [15:0] bus_word;
	logic [19:0] pin_word;

	// Write handshake: both channels taken together, one write at a time
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			awready_ff <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OK;
		end else begin
			awready_ff <= s_axi_awvalid_i & s_axi_wvalid_i & ~awready_ff & ~bvalid_ff;
			if (awready_ff) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_hit ? RESP_OK : RESP_ERR;
			end else if (s_axi_bready_i) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	assign wr_en  = awready_ff;
	assign wr_hit = (s_axi_awaddr_i == ADDR_CMD) | (s_axi_awaddr_i == ADDR_CNT) |
		(s_axi_awaddr_i == ADDR_CFG) | (s_axi_awaddr_i == ADDR_HW) | (s_axi_awaddr_i == ADDR_CAUSE);

	// Read handshake
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= RESP_OK;
		end else begin
			arready_ff <= s_axi_arvalid_i & ~arready_ff & ~rvalid_ff;
			if (arready_ff) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_word;
				rresp_ff  <= rd_hit ? RESP_OK : RESP_ERR;
			end else if (s_axi_rready_i) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr_i)
			ADDR_CMD:   rd_word = 32'h0000_0000;
			ADDR_CNT:   rd_word = cnt_ff;
			ADDR_CFG:   rd_word[CFG_WIDTH] = cfg_width_ff;
			ADDR_HW:    rd_word[7:0] = hw_ff;
			ADDR_CAUSE: rd_word[15:0] = cause_ff;
			default:    rd_hit = 1'b0;
		endcase
	end

	// Pin polarity and byte order register; reserved bit 4 is forced to zero
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || usb_bus_reset_i) begin
			hw_ff <= HW_RST;
		end else if (wr_en && s_axi_awaddr_i == ADDR_HW && s_axi_wstrb_i[0]) begin
			hw_ff <= s_axi_wdata_i[7:0] & HW_WR_MASK;
		end
	end

	// Configuration: bus width and the one-time write that releases the request pin
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || usb_bus_reset_i) begin
			cfg_width_ff   <= CFG_WIDTH_RST;
			cfg_written_ff <= 1'b0;
		end else if (wr_en && s_axi_awaddr_i == ADDR_CFG && s_axi_wstrb_i[0]) begin
			cfg_width_ff   <= s_axi_wdata_i[CFG_WIDTH];
			cfg_written_ff <= 1'b1;
		end
	end

	assign stop_req = wr_en && s_axi_awaddr_i == ADDR_CMD && s_axi_wstrb_i[0] &&
		s_axi_wdata_i[7:0] == CMD_STOP;

	// Pin synchronisers, data bus included so it lines up with the strobes
	assign pin_word = {dma_data_i, transfer_end_input_i, dma_acknowledge_input_i,
		dma_write_strobe_i, dma_read_strobe_i};

	genvar gi;
	generate
		for (gi = 0; gi < 20; gi++) begin : g_sync
			always_ff @(posedge clock_i) begin
				if (sys_rst_i) begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
				end else begin
					sync1_ff[gi] <= pin_word[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate

	// Pin level equal to the configured bit means asserted
	assign rd_act  = sync2_ff[0] ~^ hw_ff[HW_RD];
	assign wr_act  = sync2_ff[1] ~^ hw_ff[HW_WR];
	assign ack_act = sync2_ff[2] ~^ hw_ff[HW_ACK];
	assign eot_act = sync2_ff[3] ~^ hw_ff[HW_EOT];

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			act_prev_ff <= 4'h0;
		end else begin
			act_prev_ff <= {eot_act, ack_act, wr_act, rd_act};
		end
	end

	assign run      = state_ff == ST_RUN;
	assign rd_rise  = run & rd_act & ~act_prev_ff[0] & ack_act;
	assign wr_rise  = run & wr_act & ~act_prev_ff[1] & ack_act;
	assign ext_rise = run & eot_act & ~act_prev_ff[3];
	assign moves    = rd_rise | wr_rise;
	assign step     = cfg_width_ff ? STEP_WORD : STEP_BYTE;
	assign nxt_cnt  = (cnt_ff <= step) ? 32'h0000_0000 : cnt_ff - step;
	assign cnt_hit  = moves & (cnt_ff <= step);
	assign finish   = stop_req | (run & (ext_rise | short_packet_i | cnt_hit));
	assign req_on   = run & ~finish;
	assign swap     = hw_ff[HW_ORD_LO +: 2] == ORD_SWAP;

	// Byte counter: software write wins, otherwise counts down per strobe
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || usb_bus_reset_i) begin
			cnt_ff   <= 32'h0000_0000;
			start_ff <= 1'b0;
		end else begin
			start_ff <= wr_en && s_axi_awaddr_i == ADDR_CNT;
			if (wr_en && s_axi_awaddr_i == ADDR_CNT) begin
				for (int b = 0; b < 4; b++) begin
					if (s_axi_wstrb_i[b]) begin
						cnt_ff[8*b +: 8] <= s_axi_wdata_i[8*b +: 8];
					end
				end
			end else if (moves) begin
				cnt_ff <= nxt_cnt;
			end
		end
	end

	// Transfer state: a counter write arms a run once configured
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || usb_bus_reset_i) begin
			state_ff <= ST_IDLE;
		end else begin
			unique case (state_ff)
				ST_IDLE: if (start_ff && cfg_written_ff && cnt_ff != 32'h0000_0000 && !stop_req) begin
					state_ff <= ST_RUN;
				end
				ST_RUN: if (finish) begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Cut-short OUT packet is remembered until the run ends
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || usb_bus_reset_i || finish) begin
			out_cut_ff <= 1'b0;
		end else if (run && out_cut_short_i) begin
			out_cut_ff <= 1'b1;
		end
	end

	always_comb begin
		nxt_cause          = 16'h0000;
		nxt_cause[CA_CUT]  = out_cut_ff | (run & out_cut_short_i);
		nxt_cause[CA_STOP] = stop_req;
		nxt_cause[CA_EXT]  = ext_rise;
		nxt_cause[CA_INT]  = run & short_packet_i;
		nxt_cause[CA_CNT]  = cnt_hit;
	end

	// Finish reloads every bit and beats a clear in the same cycle
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || usb_bus_reset_i) begin
			cause_ff <= CA_RST;
		end else if (finish) begin
			cause_ff <= nxt_cause;
		end else if (wr_en && s_axi_awaddr_i == ADDR_CAUSE && s_axi_wstrb_i[1]) begin
			cause_ff <= cause_ff & ~(s_axi_wdata_i[15:0] & CA_CLR_M);
		end
	end

	// Request pin; held at the inactive level between runs
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			req_ff    <= 1'b0;
			req_oe_ff <= 1'b0;
		end else begin
			req_ff    <= req_on ? hw_ff[HW_REQ] : ~hw_ff[HW_REQ];
			req_oe_ff <= cfg_written_ff;
		end
	end

	// Bytes kept in memory order; the swap only touches the pin side
	assign bus_word = swap ? {sync2_ff[11:4], sync2_ff[19:12]} : sync2_ff[19:4];

	// Read path drives the bus while strobe and acknowledge stand
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			data_o_ff  <= 16'h0000;
			data_oe_ff <= 1'b0;
			rd_take_ff <= 1'b0;
		end else begin
			data_o_ff  <= swap ? {ep_rd_word_i[7:0], ep_rd_word_i[15:8]} : ep_rd_word_i;
			data_oe_ff <= run & rd_act & ack_act;
			rd_take_ff <= rd_rise;
		end
	end

	// Write path; the stop flush pushes the IN side out to the buffer
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ep_wr_word_ff  <= 16'h0000;
			ep_wr_valid_ff <= 1'b0;
			flush_ff       <= 1'b0;
		end else begin
			ep_wr_valid_ff <= wr_rise;
			flush_ff       <= stop_req;
			if (wr_rise) begin
				ep_wr_word_ff <= bus_word;
			end
		end
	end

	assign s_axi_awready_o         = awready_ff;
	assign s_axi_wready_o          = awready_ff;
	assign s_axi_bvalid_o          = bvalid_ff;
	assign s_axi_bresp_o           = bresp_ff;
	assign s_axi_arready_o         = arready_ff;
	assign s_axi_rvalid_o          = rvalid_ff;
	assign s_axi_rdata_o           = rdata_ff;
	assign s_axi_rresp_o           = rresp_ff;
	assign dma_request_output_o    = req_ff;
	assign dma_request_output_oe_o = req_oe_ff;
	assign dma_data_o              = data_o_ff;
	assign dma_data_oe_o           = data_oe_ff;
	assign ep_rd_take_o            = rd_take_ff;
	assign ep_wr_word_o            = ep_wr_word_ff;
	assign ep_wr_valid_o           = ep_wr_valid_ff;
	assign in_flush_o              = flush_ff;

	property p_order_normal;
		@(posedge clock_i) disable iff (sys_rst_i)
		!swap |=> dma_data_o == $past(ep_rd_word_i);
	endproperty
	a_order_normal: assert property (p_order_normal) else $error("Normal byte order broken");

	property p_order_swap;
		@(posedge clock_i) disable iff (sys_rst_i)
		swap |=> dma_data_o[7:0] == $past(ep_rd_word_i[15:8]) && dma_data_o[15:8] == $past(ep_rd_word_i[7:0]);
	endproperty
	a_order_swap: assert property (p_order_swap) else $error("Swapped byte order broken");

	property p_req_level;
		@(posedge clock_i) disable iff (sys_rst_i)
		req_on ##1 req_on |=> dma_request_output_o == $past(hw_ff[HW_REQ], 1);
	endproperty
	a_req_level: assert property (p_req_level) else $error("Request at wrong level");

	property p_req_hidden;
		@(posedge clock_i) disable iff (sys_rst_i || usb_bus_reset_i)
		!cfg_written_ff ##1 !cfg_written_ff |-> !dma_request_output_oe_o;
	endproperty
	a_req_hidden: assert property (p_req_hidden) else $error("Request driven before config");

	property p_clear_one;
		@(posedge clock_i) disable iff (sys_rst_i || usb_bus_reset_i)
		(wr_en && s_axi_awaddr_i == ADDR_CAUSE && s_axi_wstrb_i[1] && s_axi_wdata_i[CA_EXT] && !finish)
		|=> !cause_ff[CA_EXT];
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("Write one did not clear");

	property p_cut_hold;
		@(posedge clock_i) disable iff (sys_rst_i || usb_bus_reset_i)
		!finish |=> $stable(cause_ff[CA_CUT]);
	endproperty
	a_cut_hold: assert property (p_cut_hold) else $error("Cut-short bit changed by write");

	property p_stop_flag;
		@(posedge clock_i) disable iff (sys_rst_i || usb_bus_reset_i)
		stop_req |=> cause_ff[CA_STOP] ##1 in_flush_o == 1'b0;
	endproperty
	a_stop_flag: assert property (p_stop_flag) else $error("Stop not flagged");

	property p_count_only;
		@(posedge clock_i) disable iff (sys_rst_i || usb_bus_reset_i)
		(run && cnt_hit && !short_packet_i) |=> cause_ff[CA_CNT] && !cause_ff[CA_INT] && state_ff == ST_IDLE;
	endproperty
	a_count_only: assert property (p_count_only) else $error("Count-only end wrong");

	property p_short_only;
		@(posedge clock_i) disable iff (sys_rst_i || usb_bus_reset_i)
		(run && short_packet_i && !cnt_hit) |=> cause_ff[CA_INT] && !cause_ff[CA_CNT];
	endproperty
	a_short_only: assert property (p_short_only) else $error("Short-packet end wrong");

	property p_count_down;
		@(posedge clock_i) disable iff (sys_rst_i || usb_bus_reset_i)
		(moves && !cnt_hit && !(wr_en && s_axi_awaddr_i == ADDR_CNT)) |=> cnt_ff == $past(cnt_ff) - $past(step);
	endproperty
	a_count_down: assert property (p_count_down) else $error("Counter did not step down");

endmodule

// ==== tb/dhp_dma_model.sv ====
// Model of the external DMA controller that drives the handshake pins
`timescale 1ns/1ns
module dhp_dma_model
	import dhp_pkg::*;
(
	// Clock and configured pin levels
	input  wire logic        clock_i,
	input  wire logic [7:0]  levels_i,
	// Handshake pins and data bus
	output logic             transfer_end_o,
	output logic             ack_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic [15:0]      data_o
);
	logic        eot_on = 1'b0;
	logic        ack_on = 1'b0;
	logic        rd_on  = 1'b0;
	logic        wr_on  = 1'b0;
	logic [15:0] word   = 16'h0000;

	// Active-high intent mapped onto the configured pin level
	assign transfer_end_o = eot_on ~^ levels_i[HW_EOT];
	assign ack_o          = ack_on ~^ levels_i[HW_ACK];
	assign rd_o           = rd_on ~^ levels_i[HW_RD];
	assign wr_o           = wr_on ~^ levels_i[HW_WR];
	// Bus shows the inverse of the last word when released, so stale data cannot pass
	assign data_o = wr_on ? word : ~word;

	// One strobe; three cycles each way, above the two-cycle minimum of the synchronisers
	task automatic beat(input logic wr, input logic ack, input logic [15:0] w);
		@(posedge clock_i);
		ack_on <= ack;
		word   <= w;
		@(posedge clock_i);
		wr_on <= wr;
		rd_on <= !wr;
		repeat (3) @(posedge clock_i);
		wr_on <= 1'b0;
		rd_on <= 1'b0;
		repeat (3) @(posedge clock_i);
		ack_on <= 1'b0;
	endtask

	task automatic end_pulse();
		@(posedge clock_i);
		eot_on <= 1'b1;
		repeat (4) @(posedge clock_i);
		eot_on <= 1'b0;
	endtask
endmodule

// ==== tb/dhp_top_tb_top.sv ====
// Self-checking bench for the DMA pin polarity and interrupt cause block
`timescale 1ns/1ns
module dhp_top_tb_top
	import dhp_pkg::*;
;
	logic        clock_i = 1'b0, sys_rst_i = 1'b1, usb_bus_reset_i = 1'b0;
	logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
	logic        s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1, short_packet_i = 1'b0, out_cut_short_i = 1'b0;
	logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, hw_lvl = 8'h04;
	logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o;
	logic [3:0]  s_axi_wstrb_i = 4'h0;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic        transfer_end_input_i, dma_acknowledge_input_i, dma_read_strobe_i, dma_write_strobe_i;
	logic        dma_request_output_o, dma_request_output_oe_o, dma_data_oe_o, ep_rd_take_o, ep_wr_valid_o, in_flush_o;
	logic [15:0] dma_data_i, dma_data_o, ep_wr_word_o, last_wr, last_out;
	logic [15:0] ep_rd_word_i = 16'h1234;
	int          num_errors = 0, tests_run = 0, wr_seen = 0, flush_seen = 0;

	initial forever #2 clock_i = ~clock_i;

	dhp_top i_dhp_top (
		.clock_i, .sys_rst_i, .usb_bus_reset_i,
		.s_axi_awvalid_i, .s_axi_awaddr_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wdata_i, .s_axi_wstrb_i,
		.s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bresp_o, .s_axi_bready_i,
		.s_axi_arvalid_i, .s_axi_araddr_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rdata_o, .s_axi_rresp_o,
		.s_axi_rready_i, .transfer_end_input_i, .dma_acknowledge_input_i, .dma_read_strobe_i, .dma_write_strobe_i,
		.dma_request_output_o, .dma_request_output_oe_o, .dma_data_i, .dma_data_o, .dma_data_oe_o,
		.ep_rd_word_i, .ep_rd_take_o, .ep_wr_word_o, .ep_wr_valid_o, .in_flush_o, .short_packet_i, .out_cut_short_i
	);

	dhp_dma_model i_dhp_dma_model (
		.clock_i(clock_i), .levels_i(hw_lvl), .transfer_end_o(transfer_end_input_i),
		.ack_o(dma_acknowledge_input_i), .rd_o(dma_read_strobe_i), .wr_o(dma_write_strobe_i), .data_o(dma_data_i)
	);

	// Write and flush pulses last one cycle and read data is driven only while the strobe stands, so they are caught here rather than polled by the scenarios
	always @(posedge clock_i) begin
		if (ep_wr_valid_o === 1'b1) begin
			wr_seen++;
			last_wr = ep_wr_word_o;
		end
		if (dma_data_oe_o === 1'b1) last_out = dma_data_o;
		if (in_flush_o === 1'b1) flush_seen++;
	end

	task automatic stop_test();
		$display("errors %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic tmo(input int n);
		if (n >= 64) begin
			num_errors++;
			$display("MISMATCH %0t bus answer never came", $time);
			stop_test();
		end
	endtask

	// Ready signals are held high throughout, which the bus allows
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		s_axi_awvalid_i <= 1'b1;
		s_axi_awaddr_i  <= a;
		s_axi_wvalid_i  <= 1'b1;
		s_axi_wdata_i   <= d;
		s_axi_wstrb_i   <= s;
		n = 0;
		do begin @(posedge clock_i); n++; end while (s_axi_awready_o !== 1'b1 && n < 64);
		tmo(n);
		s_axi_awvalid_i <= 1'b0;
		s_axi_wvalid_i  <= 1'b0;
		n = 0;
		do begin @(posedge clock_i); n++; end while (s_axi_bvalid_o !== 1'b1 && n < 64);
		tmo(n);
		chk(32'(s_axi_bresp_o), 32'(er), "write response");
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
		int n;
		s_axi_arvalid_i <= 1'b1;
		s_axi_araddr_i  <= a;
		n = 0;
		do begin @(posedge clock_i); n++; end while (s_axi_arready_o !== 1'b1 && n < 64);
		tmo(n);
		s_axi_arvalid_i <= 1'b0;
		n = 0;
		do begin @(posedge clock_i); n++; end while (s_axi_rvalid_o !== 1'b1 && n < 64);
		tmo(n);
		chk(s_axi_rdata_o, exp, what);
		chk(32'(s_axi_rresp_o), 32'(er), "read response");
	endtask

	task automatic setup(input logic [7:0] hw, input logic w16, input logic [31:0] cnt);
		hw_lvl <= hw;
		axi_wr(ADDR_HW, {24'h00_0000, hw}, 4'h1, RESP_OK);
		axi_rd(ADDR_HW, {24'h00_0000, hw}, RESP_OK, "level register");
		axi_wr(ADDR_CFG, {31'h0000_0000, w16}, 4'h1, RESP_OK);
		axi_wr(ADDR_CNT, cnt, 4'hF, RESP_OK);
		repeat (4) @(posedge clock_i);
		chk(32'({dma_request_output_oe_o, dma_request_output_o}), 32'({1'b1, hw[HW_REQ]}), "request on");
	endtask

	task automatic t_reset();
		chk(32'(dma_request_output_oe_o), 32'h0000_0000, "request driven early");
		axi_rd(ADDR_HW, 32'(HW_RST), RESP_OK, "level reset");
		axi_rd(ADDR_CAUSE, 32'(CA_RST), RESP_OK, "cause reset");
		axi_rd(8'h44, 32'h0000_0000, RESP_ERR, "unmapped read");
		axi_wr(8'h44, 32'hFFFF_FFFF, 4'hF, RESP_ERR);
	endtask

	task automatic t_xfer(input logic [7:0] hw, input logic w16, input logic wr);
		logic [31:0] step;
		logic [15:0] exp;
		step = w16 ? 32'h0000_0002 : 32'h0000_0001;
		exp = (hw[7:6] == ORD_SWAP) ? 16'h3412 : 16'h1234;
		last_wr = 16'h0000;
		last_out = 16'h0000;
		setup(hw, w16, 2 * step);
		i_dhp_dma_model.beat(wr, 1'b1, 16'h1234);
		repeat (4) @(posedge clock_i);
		axi_rd(ADDR_CNT, step, RESP_OK, "count down");
		chk(32'(wr ? last_wr : last_out), 32'(exp), "byte order");
		i_dhp_dma_model.beat(wr, 1'b1, 16'h1234);
		repeat (6) @(posedge clock_i);
		axi_rd(ADDR_CAUSE, 32'h0000_0100, RESP_OK, "count done");
		chk(32'(dma_request_output_o), 32'(!hw[HW_REQ]), "request off");
	endtask

	// Strobe without acknowledge must not move data; the run is then ended by stop
	task automatic t_refuse_stop();
		setup(8'h04, 1'b1, 32'h0000_0004);
		wr_seen = 0;
		flush_seen = 0;
		i_dhp_dma_model.beat(1'b1, 1'b0, 16'hA5A5);
		repeat (4) @(posedge clock_i);
		chk(32'(wr_seen), 32'h0000_0000, "move without ack");
		out_cut_short_i <= 1'b1;
		@(posedge clock_i);
		out_cut_short_i <= 1'b0;
		axi_wr(ADDR_CMD, {24'h00_0000, CMD_STOP}, 4'h1, RESP_OK);
		repeat (6) @(posedge clock_i);
		chk(32'(flush_seen), 32'h0000_0001, "in flush");
		axi_rd(ADDR_CAUSE, 32'h0000_9000, RESP_OK, "stop cause");
		axi_wr(ADDR_CAUSE, 32'h0000_0000, 4'h2, RESP_OK);
		axi_rd(ADDR_CAUSE, 32'h0000_9000, RESP_OK, "zero write");
		axi_wr(ADDR_CAUSE, 32'h0000_9000, 4'h2, RESP_OK);
		axi_rd(ADDR_CAUSE, 32'h0000_8000, RESP_OK, "one clears");
	endtask

	task automatic t_short();
		setup(8'h04, 1'b1, 32'h0000_0008);
		i_dhp_dma_model.beat(1'b1, 1'b1, 16'h00FF);
		short_packet_i <= 1'b1;
		@(posedge clock_i);
		short_packet_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		axi_rd(ADDR_CAUSE, 32'h0000_0400, RESP_OK, "short packet");
	endtask

	task automatic t_ext(input logic [7:0] hw);
		setup(hw, 1'b1, 32'h0000_0008);
		i_dhp_dma_model.end_pulse();
		repeat (6) @(posedge clock_i);
		axi_rd(ADDR_CAUSE, 32'h0000_0800, RESP_OK, "external end");
		axi_wr(ADDR_CAUSE, 32'h0000_0800, 4'h2, RESP_OK);
		axi_rd(ADDR_CAUSE, 32'h0000_0000, RESP_OK, "external cleared");
	endtask

	task automatic t_bus_reset();
		usb_bus_reset_i <= 1'b1;
		hw_lvl <= HW_RST;
		@(posedge clock_i);
		usb_bus_reset_i <= 1'b0;
		axi_rd(ADDR_HW, 32'(HW_RST), RESP_OK, "level bus reset");
		axi_rd(ADDR_CAUSE, 32'(CA_RST), RESP_OK, "cause bus reset");
	endtask

	initial begin
		repeat (10) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
		t_reset();
		t_xfer(8'h04, 1'b1, 1'b1);
		t_xfer(8'h6F, 1'b1, 1'b1);
		t_xfer(8'h4B, 1'b1, 1'b0);
		t_xfer(8'hC4, 1'b1, 1'b0);
		t_xfer(8'h00, 1'b0, 1'b1);
		t_refuse_stop();
		t_short();
		t_ext(8'h04);
		t_ext(8'h2B);
		t_bus_reset();
		stop_test();
	end
endmodule
